// file: design/sscs_pkg.sv
// Purpose: Shared constants and types of the six-channel sample and convert sequencer.
// Assumes: A 250 MHz system clock.
// Notes: Cycle counts follow from the nominal times and the clock rate.
package sscs_pkg;
	// System clock rate in MHz.
	localparam int unsigned CLK_MHZ = 250;
	// Aperture delay from start edge to hold, in ns, rounded up to whole cycles.
	localparam int unsigned APERTURE_NS = 10;
	localparam int unsigned APERTURE_CYC = (APERTURE_NS * CLK_MHZ + 999) / 1000;
	// Conversion time in microseconds, as a cycle count.
	localparam int unsigned CONV_US = 3;
	localparam int unsigned CONV_CYC = CONV_US * CLK_MHZ;
	// Pair and channel counts.
	localparam int unsigned NUM_PAIRS = 3;
	localparam int unsigned NUM_CHANS = 6;
	// Result code width.
	localparam int unsigned CODE_W = 16;
	// Positions of the synchronised pins.
	localparam int unsigned PIN_START_A = 0;
	localparam int unsigned PIN_START_B = 1;
	localparam int unsigned PIN_START_C = 2;
	localparam int unsigned PIN_SW_MODE = 3;
	localparam int unsigned PIN_RANGE = 4;
	localparam int unsigned NUM_PINS = 5;
	// Reset value of the synchronisers: starts idle high, mode and range low.
	localparam logic [NUM_PINS-1:0] SYNC_RST = 5'h07;
	// Range code: 0 selects plus or minus 4 x reference, 1 selects 2 x reference.
	localparam logic RANGE_4X_REF = 1'h0;
	localparam logic RANGE_2X_REF = 1'h1;
	// Conversion timer states.
	typedef enum logic [1:0] {
		SSCS_IDLE = 2'b00,
		SSCS_APERTURE = 2'b01,
		SSCS_CONVERT = 2'b10
	} sscs_state_t;
endpackage : sscs_pkg

// file: design/sscs_conv_if.sv
// Purpose: Carrier between the sequencer and its conversion timer.
// Assumes: Both ends run on clk_sys_i.
// Notes: start and done are one-cycle pulses; hold and active are levels.
`timescale 1ns/10ps
interface sscs_conv_if;
	logic start;
	logic hold;
	logic done;
	logic active;
	modport ctrl (output start, input hold, input done, input active);
	modport timer (input start, output hold, output done, output active);
endinterface : sscs_conv_if

// file: design/sscs_conv_timer.sv
// Purpose: Times one conversion: aperture delay, then hold until the conversion ends.
// Assumes: start arrives only while the timer is idle.
// Notes: From the cycle after start up to and including done is CONV_CYCLES cycles.
`timescale 1ns/10ps
module sscs_conv_timer
	import sscs_pkg::*;
#(
	parameter int unsigned APERTURE_CYCLES = APERTURE_CYC,
	parameter int unsigned CONV_CYCLES = CONV_CYC,
	parameter int unsigned CNT_W = 12
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Link to the sequencer.
	sscs_conv_if.timer conv
);
	sscs_state_t state;
	logic [CNT_W-1:0] cnt;

	generate
		if (APERTURE_CYCLES < 1 || APERTURE_CYCLES >= CONV_CYCLES) begin : g_bad_timing
			$error("Aperture must be at least one cycle and shorter than the conversion.");
		end
		if (CONV_CYCLES > (2 ** CNT_W)) begin : g_bad_cnt
			$error("Counter too narrow for the conversion count.");
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state <= SSCS_IDLE;
			cnt <= '0;
		end else begin
			case (state)
				SSCS_IDLE: begin
					cnt <= '0;
					if (conv.start) begin
						state <= SSCS_APERTURE;
					end
				end
				SSCS_APERTURE: begin
					cnt <= cnt + 1'b1;
					if (cnt == CNT_W'(APERTURE_CYCLES - 1)) begin
						state <= SSCS_CONVERT; // [RQ9]
					end
				end
				SSCS_CONVERT: begin
					cnt <= cnt + 1'b1;
					if (cnt == CNT_W'(CONV_CYCLES - 1)) begin
						state <= SSCS_IDLE; // [RQ5]
					end
				end
				default: begin
					state <= SSCS_IDLE;
				end
			endcase
		end
	end

	// The internal cycle count alone times the conversion.
	assign conv.hold = (state == SSCS_CONVERT); // [RQ9]
	assign conv.done = (state == SSCS_CONVERT) && (cnt == CNT_W'(CONV_CYCLES - 1)); // [RQ5]
	assign conv.active = (state != SSCS_IDLE);
endmodule : sscs_conv_timer

// file: design/sscs_sequencer.sv
// Purpose: Conversion sequencing for three channel pairs of a six-channel converter.
// Assumes: Start, mode and range pins are asynchronous; other inputs share clk_sys_i.
// Notes: The core delivers offset-binary codes that are valid when a conversion ends.
// What this block does
// RQ1: Three start inputs, one per channel pair.
// RQ2: Common start signal samples all six together.
// RQ3: Rising start edge holds pair, starts conversion.
// RQ4: Busy rises after edge, high while converting.
// RQ5: Internal timing, conversion lasts three microseconds.
// RQ6: Busy falls when conversion completes.
// RQ7: Busy fall returns pairs to track.
// RQ8: Range selects four or two times reference.
// RQ9: Hold follows start edge by 10 ns.
// RQ10: Completed results land in output registers.
// RQ11: Results coded in two's complement.
// RQ12: Reset aborts conversion, clears registers; needs fresh pulse.
// RQ13: Pins pick pairs; software mode starts on A.
// RQ14: Hardware mode samples range pin at busy fall.
// RQ15: Start edges during busy are ignored.
`timescale 1ns/10ps
module sscs_sequencer
	import sscs_pkg::*;
#(
	parameter int unsigned APERTURE_CYCLES = APERTURE_CYC,
	parameter int unsigned CONV_CYCLES = CONV_CYC,
	parameter int unsigned CODE_WIDTH = CODE_W
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Start pins, one per channel pair.
	input wire logic pair_a_sample_start_i,
	input wire logic pair_b_sample_start_i,
	input wire logic pair_c_sample_start_i,
	// Mode and range pins.
	input wire logic sw_mode_i,
	input wire logic range_pin_i,
	// Software-mode settings from the control register.
	input wire logic [NUM_PAIRS-1:0] sw_pair_select_i,
	input wire logic [NUM_PAIRS-1:0] range_select_bits_i,
	// Converter core codes, offset binary, channel 1 in the low bits.
	input wire logic [NUM_CHANS*CODE_WIDTH-1:0] core_code_i,
	// Conversion status.
	output logic busy_o,
	output logic [NUM_PAIRS-1:0] pair_hold_o,
	output logic [NUM_PAIRS-1:0] pair_range_o,
	output logic start_ignored_o,
	// Results, two's complement, channel 1 in the low bits.
	output logic [NUM_CHANS*CODE_WIDTH-1:0] result_o,
	output logic result_valid_o
);
	// Counter width covers the whole conversion count.
	localparam int unsigned CNT_W = $clog2(CONV_CYCLES + 1);

	generate
		if (APERTURE_CYCLES < 1 || APERTURE_CYCLES >= CONV_CYCLES) begin : g_bad_timing
			$error("Aperture must be at least one cycle and shorter than the conversion.");
		end
		if (CODE_WIDTH < 2) begin : g_bad_width
			$error("Result codes need at least two bits.");
		end
		if (NUM_CHANS != 2 * NUM_PAIRS) begin : g_bad_pairs
			$error("Every pair must hold exactly two channels.");
		end
		if (PIN_START_C - PIN_START_A + 1 != NUM_PAIRS) begin : g_bad_pins
			$error("Start pin positions must be contiguous, one per pair.");
		end
	endgenerate

	// Synchronised pins, start edges and conversion bookkeeping.
	logic [NUM_PINS-1:0] pins_raw;
	logic [NUM_PINS-1:0] pins_meta;
	logic [NUM_PINS-1:0] pins_sync;
	logic [NUM_PAIRS-1:0] start_prev;
	logic [NUM_PAIRS-1:0] start_rise;
	logic [NUM_PAIRS-1:0] trigger;
	logic [NUM_PAIRS-1:0] pair_active;
	logic busy;
	logic range_latch;
	logic mode_sw;

	// Carrier to the conversion timer.
	sscs_conv_if conv ();

	// Pin order follows the package pin positions.
	assign pins_raw = {range_pin_i, sw_mode_i, pair_c_sample_start_i,
		pair_b_sample_start_i, pair_a_sample_start_i}; // [RQ1]

	// Two-stage synchronisers; starts reset high so a fresh low is needed first.
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_sync
			always_ff @(posedge clk_sys_i) begin
				if (srst_i) begin
					pins_meta[gp] <= SYNC_RST[gp];
					pins_sync[gp] <= SYNC_RST[gp];
				end else begin
					pins_meta[gp] <= pins_raw[gp];
					pins_sync[gp] <= pins_meta[gp];
				end
			end
		end
	endgenerate

	// Previous start levels; reset high so only a low-then-high pulse counts.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			start_prev <= '1; // [RQ12]
		end else begin
			start_prev <= pins_sync[PIN_START_C:PIN_START_A];
		end
	end

	// A start edge is a synchronised high that was low one cycle earlier.
	assign start_rise = pins_sync[PIN_START_C:PIN_START_A] & ~start_prev; // [RQ3]
	assign mode_sw = pins_sync[PIN_SW_MODE];

	// Hardware mode: each pin starts its pair. Software mode: pair A starts the selection.
	always_comb begin
		if (mode_sw) begin
			trigger = start_rise[PIN_START_A] ? sw_pair_select_i : '0; // [RQ13]
		end else begin
			trigger = start_rise; // [RQ13]
		end
	end

	// Pins tied together rise in the same cycle and, in hardware mode, start all pairs at once.
	assign conv.start = (|trigger) && !busy; // [RQ2] [RQ15]

	// Busy rises the cycle after a start is taken and falls after the done cycle.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			busy <= 1'b0; // [RQ12]
		end else if (conv.start) begin
			busy <= 1'b1; // [RQ4]
		end else if (conv.done) begin
			busy <= 1'b0; // [RQ6]
		end
	end

	assign busy_o = busy;

	// Pairs taking part in the running conversion; all return to track at busy fall.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pair_active <= '0;
		end else if (conv.start) begin
			pair_active <= trigger; // [RQ3]
		end else if (conv.done) begin
			pair_active <= '0; // [RQ7]
		end
	end

	// Hold shows only after the aperture, and only for pairs that started.
	assign pair_hold_o = conv.hold ? pair_active : '0; // [RQ9] [RQ7]

	// Start edges that arrive while busy are dropped, not queued; this pulse reports one.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			start_ignored_o <= 1'b0;
		end else begin
			start_ignored_o <= (|trigger) && busy; // [RQ15]
		end
	end

	// Range pin level at the end of each hardware-mode conversion serves the next one.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			range_latch <= RANGE_4X_REF;
		end else if (conv.done && !mode_sw) begin
			range_latch <= pins_sync[PIN_RANGE]; // [RQ14]
		end
	end

	// Each started pair takes its range at the start: the register bit in software mode,
	// the level latched at the last busy fall in hardware mode.
	genvar gr;
	generate
		for (gr = 0; gr < NUM_PAIRS; gr++) begin : g_range
			always_ff @(posedge clk_sys_i) begin
				if (srst_i) begin
					pair_range_o[gr] <= RANGE_4X_REF;
				end else if (conv.start && trigger[gr]) begin
					pair_range_o[gr] <= mode_sw ? range_select_bits_i[gr] : range_latch; // [RQ8]
				end
			end
		end
	endgenerate

	// The timer alone paces the conversion, so no outside conversion clock is needed.
	sscs_conv_timer #(
		.APERTURE_CYCLES(APERTURE_CYCLES),
		.CONV_CYCLES(CONV_CYCLES),
		.CNT_W(CNT_W)
	) u_timer (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.conv(conv)
	);

	// Result registers; flipping the sign bit turns offset binary into two's complement.
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CHANS; gc++) begin : g_result
			always_ff @(posedge clk_sys_i) begin
				if (srst_i) begin
					result_o[gc*CODE_WIDTH +: CODE_WIDTH] <= '0; // [RQ12]
				end else if (conv.done && pair_active[gc/2]) begin
					result_o[gc*CODE_WIDTH +: CODE_WIDTH] <= {
						~core_code_i[gc*CODE_WIDTH + CODE_WIDTH - 1],
						core_code_i[gc*CODE_WIDTH +: CODE_WIDTH-1]}; // [RQ10] [RQ11]
				end
			end
		end
	endgenerate

	// Valid pulses once, in the first cycle of new results with busy low.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			result_valid_o <= 1'b0;
		end else begin
			result_valid_o <= conv.done; // [RQ10]
		end
	end
endmodule : sscs_sequencer

// file: verification/sscs_chk.sv
// Purpose: Port timing checks for the sequencer.
// Assumes: An aperture of 3 cycles.
// Notes: Bound into every sequencer instance.
`timescale 1ns/10ps
module sscs_chk #(parameter int unsigned CONV_CYCLES = 20) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic pair_a_sample_start_i,
	input wire logic sw_mode_i,
	input wire logic [2:0] sw_pair_select_i,
	input wire logic [2:0] range_select_bits_i,
	input wire logic busy_o,
	input wire logic [2:0] pair_hold_o,
	input wire logic [2:0] pair_range_o,
	input wire logic start_ignored_o,
	input wire logic result_valid_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	int unsigned n;
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !busy_o) begin
			n <= 0;
		end else begin
			n <= n + 1;
		end
	end
	sequence s_aperture;
		(pair_hold_o == 3'h0) [*3] ##1 (pair_hold_o != 3'h0);
	endsequence
	property p_len; $fell(busy_o) |-> n == CONV_CYCLES; endproperty
	property p_aper; $rose(busy_o) |-> s_aperture; endproperty
	property p_track; !busy_o |-> pair_hold_o == 3'h0; endproperty
	property p_valid; result_valid_o == $fell(busy_o); endproperty
	property p_ign; start_ignored_o |-> $past(busy_o); endproperty
	property p_rng; busy_o && $past(busy_o) |-> $stable(pair_range_o); endproperty
	property p_start;
		$rose(pair_a_sample_start_i) && !busy_o && !sw_mode_i |-> ##[1:4] $rose(busy_o);
	endproperty
	property p_sw;
		$rose(busy_o) && sw_mode_i |->
			((pair_range_o ^ $past(range_select_bits_i)) & $past(sw_pair_select_i)) == 3'h0;
	endproperty
	a_len: assert property (p_len) else $error("busy length wrong");
	a_aper: assert property (p_aper) else $error("hold delay wrong");
	a_track: assert property (p_track) else $error("hold while idle");
	a_valid: assert property (p_valid) else $error("valid not at busy fall");
	a_ign: assert property (p_ign) else $error("stray ignore pulse");
	a_rng: assert property (p_rng) else $error("range moved in busy");
	a_start: assert property (p_start) else $error("start not taken");
	a_sw: assert property (p_sw) else $error("software range wrong");
endmodule : sscs_chk
bind sscs_sequencer sscs_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.clk_sys_i, .srst_i,
	.pair_a_sample_start_i, .sw_mode_i, .sw_pair_select_i, .range_select_bits_i, .busy_o,
	.pair_hold_o, .pair_range_o, .start_ignored_o, .result_valid_o);

// file: verification/sscs_host.sv
// Purpose: Host model that pulses the start pins.
// Assumes: Commands come at least three cycles apart.
// Notes: Selected pins go low for two cycles, then rise together.
`timescale 1ns/10ps
module sscs_host (
	input wire logic clk_sys_i,
	input wire logic go_i,
	input wire logic [2:0] mask_i,
	output logic [2:0] pins_o
);
	logic [1:0] cnt = 2'h0;
	initial pins_o = 3'h7;
	always @(negedge clk_sys_i) begin
		if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
			if (cnt == 2'h1) begin
				pins_o <= 3'h7;
			end
		end else if (go_i) begin
			pins_o <= ~mask_i;
			cnt <= 2'h2;
		end
	end
endmodule : sscs_host

// file: verification/tb_six_channel_sample_convert_sequencer.sv
// Purpose: Self-checking bench for the sequencer.
// Assumes: Short conversion count for speed.
// Notes: Inputs change on the falling edge.
`timescale 1ns/10ps
module tb_six_channel_sample_convert_sequencer;
	localparam int unsigned CONV_N = 20;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic go = 1'b0;
	logic [2:0] mask = 3'h7;
	logic [2:0] pins;
	logic sw_mode_i = 1'b0;
	logic range_pin_i = 1'b0;
	logic [2:0] sw_pair_select_i = 3'h0;
	logic [2:0] range_select_bits_i = 3'h0;
	logic [95:0] core_code_i = 96'h0;
	logic busy_o, start_ignored_o, result_valid_o;
	logic [2:0] pair_hold_o, pair_range_o;
	logic [95:0] result_o;
	logic [95:0] exp_res = 96'h0;
	int fail_count = 0;
	int cmp_count = 0;
	sscs_host u_host (.clk_sys_i, .go_i(go), .mask_i(mask), .pins_o(pins));
	sscs_sequencer #(.APERTURE_CYCLES(3), .CONV_CYCLES(CONV_N)) dut_u (.clk_sys_i, .srst_i,
		.pair_a_sample_start_i(pins[0]), .pair_b_sample_start_i(pins[1]),
		.pair_c_sample_start_i(pins[2]), .sw_mode_i, .range_pin_i, .sw_pair_select_i,
		.range_select_bits_i, .core_code_i, .busy_o, .pair_hold_o, .pair_range_o,
		.start_ignored_o, .result_o, .result_valid_o);
	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic report_and_stop;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic pulse(input logic [2:0] m);
		mask <= m;
		go <= 1'b1;
		@(negedge clk_sys_i);
		go <= 1'b0;
	endtask : pulse
	// Runs one conversion; a late pulse on other pins lands mid-conversion.
	task automatic conv(input logic [2:0] pm, input logic [2:0] m, input logic [2:0] late,
		input logic [2:0] range_select_bits);
		int n;
		logic ign;
		n = 0;
		ign = 1'b0;
		pulse(pm);
		repeat (10) if (busy_o !== 1'b1) @(negedge clk_sys_i);
		while (busy_o === 1'b1 && n < 99) begin
			n++;
			ign = ign | start_ignored_o;
			if (n == 4) begin
				mask <= late;
				go <= late != 3'h0;
			end
			if (n == 5) go <= 1'b0;
			if (n == 10) begin
				check(pair_hold_o, m);
				check(pair_range_o & m, range_select_bits & m);
			end
			@(negedge clk_sys_i);
		end
		check(ign, late != 3'h0);
		check(n, CONV_N);
		for (int p = 0; p < 3; p++) begin
			if (m[p]) exp_res[p*32 +: 32] = core_code_i[p*32 +: 32] ^ 32'h80008000;
		end
		check(result_o, exp_res);
		check(result_valid_o, 1'b1);
		check(pair_hold_o, 3'h0);
	endtask : conv
	task automatic t_simul;
		core_code_i <= 96'h8000_7FFF_0000_FFFF_1234_C0DE;
		range_pin_i <= 1'b1;
		conv(3'h7, 3'h7, 3'h0, 3'h0);
	endtask : t_simul
	task automatic t_pair_ignore;
		core_code_i <= 96'h1111_2222_3333_4444_5555_6666;
		range_pin_i <= 1'b0;
		conv(3'h2, 3'h2, 3'h4, 3'h7);
	endtask : t_pair_ignore
	task automatic t_range;
		// A level raised after the last busy fall must wait for the next fall.
		range_pin_i <= 1'b1;
		conv(3'h1, 3'h1, 3'h0, 3'h0);
	endtask : t_range
	task automatic t_sw;
		sw_mode_i <= 1'b1;
		sw_pair_select_i <= 3'h5;
		range_select_bits_i <= 3'h4;
		pulse(3'h2);
		repeat (12) @(negedge clk_sys_i);
		check(busy_o, 1'b0);
		conv(3'h1, 3'h5, 3'h0, 3'h4);
	endtask : t_sw
	task automatic t_reset;
		sw_mode_i <= 1'b0;
		pulse(3'h7);
		repeat (10) if (busy_o !== 1'b1) @(negedge clk_sys_i);
		srst_i <= 1'b1;
		repeat (3) @(negedge clk_sys_i);
		srst_i <= 1'b0;
		@(negedge clk_sys_i);
		exp_res = 96'h0;
		check(busy_o, 1'b0);
		check(result_o, exp_res);
		conv(3'h7, 3'h7, 3'h0, 3'h0);
	endtask : t_reset
	initial begin
		repeat (12) @(negedge clk_sys_i);
		srst_i <= 1'b0;
		repeat (2) @(negedge clk_sys_i);
		t_simul();
		t_pair_ignore();
		t_range();
		t_sw();
		t_reset();
		report_and_stop();
	end
	initial begin
		#20000;
		fail_count++;
		report_and_stop();
	end
endmodule : tb_six_channel_sample_convert_sequencer
